// ===== verilog/tcc_defines.svh
/*
  Offsets, field positions, reset values and fixed widths of the capture/compare timer.
  Assumes APB byte addressing with one aligned 32-bit word per register.
*/
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

`define TCC_ADDR_W 12
`define TCC_OFF_CTRL0 12'h000
`define TCC_OFF_CTRL1 12'h004
`define TCC_OFF_COUNT 12'h008
`define TCC_OFF_RELOAD 12'h00c
`define TCC_OFF_CAPTURE 12'h010
`define TCC_OFF_STATUS 12'h014

`define TCC_CTRL0_EN 0
`define TCC_CTRL0_MODE_LSB 1
`define TCC_CTRL0_MODE_MSB 3
`define TCC_CTRL0_PRES_LSB 4
`define TCC_CTRL0_PRES_MSB 6
`define TCC_CTRL0_POL 7

`define TCC_CTRL1_MODE_HI 0
`define TCC_CTRL1_SRC_LSB 1
`define TCC_CTRL1_SRC_MSB 2
`define TCC_CTRL1_CAUSE 3
`define TCC_CTRL1_OUT_EN 4

`define TCC_CTRL0_RST 8'h00
`define TCC_CTRL1_RST 5'h00
`define TCC_COUNT_RST 16'h0001
`define TCC_RELOAD_RST 16'hffff
`define TCC_CAPTURE_RST 16'h0000
`define TCC_RESTART_VAL 16'h0001
`define TCC_WRAP_VAL 16'hffff

`endif

// ===== verilog/tcc_pkg.sv
/*
  Types of the capture/compare timer: operating modes and interrupt source choices.
  Assumes the mode code is the upper select bit joined to the three-bit control field.
*/
package tcc_pkg;

  typedef enum logic [3:0] {
    TCC_MODE_COMPARE = 4'h2,
    TCC_MODE_GATED = 4'h6,
    TCC_MODE_CAPCMP = 4'h7,
    TCC_MODE_CAPRST = 4'h8
  } tcc_mode_t;

  typedef enum logic [1:0] {
    TCC_SRC_BOTH = 2'h0,
    TCC_SRC_INPUT = 2'h1,
    TCC_SRC_RELOAD = 2'h2,
    TCC_SRC_BOTH_ALT = 2'h3
  } tcc_src_t;

endpackage

// ===== verilog/tcc_input_sync.sv
/*
  Two-stage synchroniser and edge detector for the timer input pin.
  Assumes the pin is asynchronous to pclk; edges are one pclk wide.
*/
`timescale 1ns/1ps
module tcc_input_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule

// ===== verilog/tcc_prescaler.sv
/*
  Prescaler: one-cycle tick every 2**exp pclk cycles while run is high.
  Assumes exp is held steady while run is high.
*/
`timescale 1ns/1ps
module tcc_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] exp,
  output logic tick
);
  logic [6:0] div_reg;
  logic [6:0] limit;

  assign limit = 7'((8'h01 << exp) - 8'h01);
  assign tick = run && (div_reg == limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 7'h00;
    end else if (!run || tick) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end
endmodule

// ===== verilog/tcc_timer.sv
/*
  16-bit capture/compare timer with capture-restart, compare, gated and
  capture/compare modes, reached over APB.
  Assumes a 20 MHz pclk and an asynchronous timer input pin; the interrupt
  output is a one-cycle pulse for an external interrupt controller.
*/
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tcc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_en,
  output logic timer_irq
);
  logic [7:0] ctrl0_reg;
  logic [4:0] ctrl1_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_reg;
  logic [15:0] capture_reg;
  logic cause_reg;
  logic started_reg;
  logic tout_reg;
  logic irq_reg;
  logic [31:0] rdata_reg;

  logic [`TCC_ADDR_W-1:0] addr;
  logic hit;
  logic wr;
  logic en;
  logic pol;
  logic [1:0] src;
  tcc_pkg::tcc_mode_t mode;
  logic is_caprst;
  logic is_cmp;
  logic is_gated;
  logic is_capcmp;
  logic in_level;
  logic in_rise;
  logic in_fall;
  logic active;
  logic sel_edge;
  logic deassert;
  logic tick;
  logic adv;
  logic at_limit;
  logic cap_ev;
  logic first_ev;
  logic gate_ev;
  logic rld_ev;
  logic cmp_ev;
  logic cnt_wr;
  logic in_irq_ok;
  logic rld_irq_ok;

  // register decode
  assign addr = paddr[`TCC_ADDR_W-1:0];
  always_comb begin
    unique case (addr)
      `TCC_OFF_CTRL0, `TCC_OFF_CTRL1, `TCC_OFF_COUNT, `TCC_OFF_RELOAD,
      `TCC_OFF_CAPTURE, `TCC_OFF_STATUS: hit = (paddr[31:`TCC_ADDR_W] == 20'h00000);
      default: hit = 1'b0;
    endcase
  end
  assign wr = psel && penable && pwrite && hit;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit;
  assign prdata = rdata_reg;

  // read data is latched in the setup cycle, so every access is zero-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h00000000;
    end else if (psel && !penable) begin
      unique case (addr)
        `TCC_OFF_CTRL0: rdata_reg <= {24'h000000, ctrl0_reg};
        `TCC_OFF_CTRL1: rdata_reg <= {27'h0000000, ctrl1_reg[4], cause_reg, ctrl1_reg[2:0]};
        `TCC_OFF_COUNT: rdata_reg <= {16'h0000, count_reg};
        `TCC_OFF_RELOAD: rdata_reg <= {16'h0000, reload_reg};
        `TCC_OFF_CAPTURE: rdata_reg <= {16'h0000, capture_reg};
        `TCC_OFF_STATUS: rdata_reg <= {29'h00000000, in_level, started_reg, tout_reg};
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= `TCC_CTRL0_RST;
      ctrl1_reg <= `TCC_CTRL1_RST;
      reload_reg <= `TCC_RELOAD_RST;
    end else if (wr) begin
      if (addr == `TCC_OFF_CTRL0) begin
        ctrl0_reg <= pwdata[7:0];
      end
      if (addr == `TCC_OFF_CTRL1) begin
        // the cause bit belongs to hardware; software writes to it are dropped
        ctrl1_reg <= {pwdata[4], 1'b0, pwdata[2:0]};
      end
      if (addr == `TCC_OFF_RELOAD) begin
        reload_reg <= pwdata[15:0];
      end
    end
  end

  assign en = ctrl0_reg[`TCC_CTRL0_EN];
  assign pol = ctrl0_reg[`TCC_CTRL0_POL];
  assign src = ctrl1_reg[`TCC_CTRL1_SRC_MSB:`TCC_CTRL1_SRC_LSB];
  // the upper mode bit lives in the second control register
  assign mode = tcc_pkg::tcc_mode_t'({ctrl1_reg[`TCC_CTRL1_MODE_HI],
                ctrl0_reg[`TCC_CTRL0_MODE_MSB:`TCC_CTRL0_MODE_LSB]});
  assign is_caprst = en && (mode == tcc_pkg::TCC_MODE_CAPRST);
  assign is_cmp = en && (mode == tcc_pkg::TCC_MODE_COMPARE);
  assign is_gated = en && (mode == tcc_pkg::TCC_MODE_GATED);
  assign is_capcmp = en && (mode == tcc_pkg::TCC_MODE_CAPCMP);

  tcc_input_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_in),
    .level(in_level),
    .rise(in_rise),
    .fall(in_fall)
  );

  // polarity 0: rising edge / high active; polarity 1: falling edge / low active
  assign sel_edge = pol ? in_fall : in_rise;
  assign deassert = pol ? in_rise : in_fall;
  assign active = pol ? !in_level : in_level;

  // the pin never clocks the counter; it only gates or captures
  tcc_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .run(is_caprst || is_cmp || is_gated || is_capcmp),
    .exp(ctrl0_reg[`TCC_CTRL0_PRES_MSB:`TCC_CTRL0_PRES_LSB]),
    .tick(tick)
  );

  assign adv = tick && (!is_gated || active) && (!is_capcmp || started_reg);
  assign at_limit = (count_reg == reload_reg);
  assign cap_ev = sel_edge && (is_caprst || (is_capcmp && started_reg));
  assign first_ev = sel_edge && is_capcmp && !started_reg;
  assign gate_ev = is_gated && deassert;
  // a capture in the same cycle pre-empts the reload
  assign rld_ev = adv && at_limit && !is_cmp && !cap_ev;
  assign cmp_ev = adv && at_limit && is_cmp;
  assign cnt_wr = wr && (addr == `TCC_OFF_COUNT);

  // capture/compare arms on the first selected edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_reg <= 1'b0;
    end else if (!is_capcmp) begin
      started_reg <= 1'b0;
    end else if (first_ev) begin
      started_reg <= 1'b1;
    end
  end

  // counter; a software write wins but is only safe while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `TCC_COUNT_RST;
    end else if (cnt_wr) begin
      count_reg <= pwdata[15:0];
    end else if (cap_ev || rld_ev) begin
      count_reg <= `TCC_RESTART_VAL;
    end else if (adv) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // capture pair; hardware capture beats a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reg <= `TCC_CAPTURE_RST;
    end else if (cap_ev) begin
      capture_reg <= count_reg;
    end else if (wr && (addr == `TCC_OFF_CAPTURE)) begin
      capture_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= 1'b0;
    end else if (cap_ev) begin
      cause_reg <= 1'b1;
    end else if (rld_ev && (is_caprst || is_capcmp)) begin
      cause_reg <= 1'b0;
    end
  end

  // source select: input-only blocks reload events, reload-only blocks input events
  assign in_irq_ok = (src != tcc_pkg::TCC_SRC_RELOAD);
  assign rld_irq_ok = (src != tcc_pkg::TCC_SRC_INPUT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ((cap_ev || gate_ev) && in_irq_ok) ||
                 ((rld_ev || cmp_ev) && rld_irq_ok);
    end
  end
  assign timer_irq = irq_reg;

  // output sits at its initial level while disabled and toggles on each compare match or reload once enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_reg <= 1'b0;
    end else if (!en) begin
      tout_reg <= pol;
    end else if (cmp_ev || rld_ev) begin
      tout_reg <= !tout_reg;
    end
  end
  assign timer_out = tout_reg;
  assign timer_out_en = ctrl1_reg[`TCC_CTRL1_OUT_EN];

  AST_CAPRST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
    (is_caprst && sel_edge && !cnt_wr) |=>
      (capture_reg == $past(count_reg)) && (count_reg == 16'h0001))
    else $error("capture-restart did not capture and restart");
  AST_EDGE_POLARITY: assert property (@(posedge pclk) disable iff (!presetn)
    (is_caprst && in_rise && pol) |-> !cap_ev)
    else $error("wrong edge accepted for capture");
  AST_CAPRST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_caprst && sel_edge && src == 2'h0) |=> timer_irq ##1 !timer_irq)
    else $error("capture interrupt missing or not a pulse");
  AST_CAUSE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev |=> ctrl1_reg[`TCC_CTRL1_CAUSE] == 1'b0 && cause_reg)
    else $error("capture cause flag not set");
  AST_RELOAD_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    (is_caprst && adv && at_limit && !sel_edge && !cnt_wr) |=>
      count_reg == 16'h0001 && !cause_reg)
    else $error("reload did not restart count");
  AST_CAUSE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (rld_ev && is_capcmp) |=> !cause_reg)
    else $error("capture cause flag not cleared on reload");
  AST_SRC_RELOAD_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (src == 2'h2 && !rld_ev && !cmp_ev) |=> !timer_irq)
    else $error("input event interrupted with reload-only source");
  AST_CMP_NO_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_ev && !cnt_wr) |=> count_reg == 16'($past(count_reg) + 16'h0001))
    else $error("compare match disturbed the count");
  AST_CMP_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_ev && en) |=> tout_reg != $past(tout_reg))
    else $error("output did not toggle on compare");
  AST_CMP_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    (is_cmp && adv && count_reg == `TCC_WRAP_VAL && !cnt_wr) |=> count_reg == 16'h0000)
    else $error("compare mode did not wrap to zero");
  AST_GATE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (is_gated && !active && !cnt_wr) |=> $stable(count_reg))
    else $error("gated count moved while input inactive");
  AST_GATE_DEASSERT_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_gated && deassert && src == 2'h1) |=> timer_irq)
    else $error("deassertion interrupt missing");
  AST_GATE_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (is_gated && rld_ev && !cnt_wr) |=>
      count_reg == 16'h0001 && tout_reg != $past(tout_reg))
    else $error("gated reload did not restart and toggle");
  AST_CAPCMP_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    first_ev |=> started_reg && !timer_irq)
    else $error("first edge mishandled");
  AST_CAPCMP_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    (is_capcmp && !started_reg && !sel_edge && !cnt_wr) |=> $stable(count_reg))
    else $error("capture/compare counted before first edge");
  AST_TICK_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && ctrl0_reg[`TCC_CTRL0_PRES_MSB:`TCC_CTRL0_PRES_LSB] != 3'h0) |=> !tick)
    else $error("prescaler ticked on consecutive cycles");
  AST_NO_TICK_NO_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (!tick && !cap_ev && !cnt_wr) |=> $stable(count_reg))
    else $error("count moved without a prescaler tick");
  AST_CAPCMP_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
    (is_capcmp && started_reg && sel_edge && !cnt_wr) |=>
      capture_reg == $past(count_reg) && count_reg == 16'h0001 && cause_reg)
    else $error("capture/compare edge did not capture and restart");
  AST_CAPCMP_CAP_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_capcmp && started_reg && sel_edge && src != 2'h2) |=> timer_irq)
    else $error("capture/compare capture interrupt missing");
  AST_CAPCMP_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (is_capcmp && rld_ev && !cnt_wr) |=> count_reg == 16'h0001 && !cause_reg)
    else $error("capture/compare limit did not restart count");
  AST_CAPCMP_RLD_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_capcmp && rld_ev && src != 2'h1) |=> timer_irq)
    else $error("capture/compare limit interrupt missing");
  AST_GATE_RLD_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_gated && rld_ev && src != 2'h1) |=> timer_irq)
    else $error("gated reload interrupt missing");
  AST_GATE_SRC_INPUT_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (is_gated && src == 2'h1 && !gate_ev) |=> !timer_irq)
    else $error("gated reload interrupted with input-only source");
  AST_GATE_DEFAULT_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_gated && deassert && src == 2'h0) |=> timer_irq)
    else $error("default source missed a deassertion interrupt");
  AST_GATE_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (is_gated && active && tick && !at_limit && !cnt_wr) |=>
      count_reg == 16'($past(count_reg) + 16'h0001))
    else $error("gated count did not advance while input active");
  AST_CAPRST_RLD_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_caprst && rld_ev && src != 2'h1) |=> timer_irq)
    else $error("capture-restart reload interrupt missing");
  AST_SRC_INPUT_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (src == 2'h1 && !cap_ev && !gate_ev) |=> !timer_irq)
    else $error("reload interrupted with input-only source");
  AST_CAPRST_CAUSE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (rld_ev && is_caprst) |=> !cause_reg)
    else $error("capture cause flag kept after reload");
  AST_CMP_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_ev && src != 2'h1) |=> timer_irq)
    else $error("compare interrupt missing");
  AST_CMP_CAUSE_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
    is_cmp |=> $stable(cause_reg))
    else $error("compare mode changed the capture cause flag");
  AST_CAP_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (cap_ev && src != 2'h2) |=> timer_irq)
    else $error("capture interrupt missing");
  AST_OUT_IDLE_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    !en |=> tout_reg == $past(pol))
    else $error("output not at its initial level while disabled");
  AST_OUT_STEADY: assert property (@(posedge pclk) disable iff (!presetn)
    (en && !cmp_ev && !rld_ev) |=> $stable(tout_reg))
    else $error("output moved without a match or reload");
  AST_CAPCMP_FIRST_NO_CAP: assert property (@(posedge pclk) disable iff (!presetn)
    (first_ev && !wr) |=> $stable(capture_reg))
    else $error("first edge captured the count");
  AST_CAPCMP_DISARM: assert property (@(posedge pclk) disable iff (!presetn)
    !is_capcmp |=> !started_reg)
    else $error("capture/compare stayed armed outside its mode");
  AST_CAUSE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!cap_ev && !rld_ev) |=> $stable(cause_reg))
    else $error("capture cause flag moved without an event");
  AST_GATE_OUT_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    (is_gated && rld_ev) |=> tout_reg != $past(tout_reg))
    else $error("gated reload did not toggle the output");
endmodule

// ===== sim/tcc_input_source.sv
/*
  External source for the timer input pin: moves the pin toward the level the bench asks for.
  Assumes pclk from the bench; lag adds that many cycles before each change.
*/
`timescale 1ns/1ps
module tcc_input_source (
  input wire logic pclk,
  input wire logic want,
  input wire logic [3:0] lag,
  output logic timer_in
);
  logic [3:0] wait_cnt = 4'h0;
  logic pin_reg = 1'b0;
  assign timer_in = pin_reg;
  // the pin is always driven, so the old level stays until a slow source catches up
  always @(posedge pclk) begin
    if (want == pin_reg) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= lag) begin
      pin_reg <= want;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ===== sim/timer_capture_compare_gated_modes_tb.sv
/*
  Self-checking bench for the capture/compare timer: APB master, input source, mode scenarios.
  Assumes the register map and zero-wait APB slave of the timer top module.
*/
`timescale 1ns/1ps
`include "tcc_defines.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, s); end end
module timer_capture_compare_gated_modes_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, serr, timer_in, timer_out, timer_out_en, timer_irq, g;
  logic lvl = 1'b0;
  logic [3:0] lag = 4'h0;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;

  always #25 pclk = ~pclk;

  tcc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_in(timer_in), .timer_out(timer_out),
    .timer_out_en(timer_out_en), .timer_irq(timer_irq));
  tcc_input_source SRC (.pclk(pclk), .want(lvl), .lag(lag), .timer_in(timer_in));

  task automatic stop_test;
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test;
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // the window always runs its full length so later timing stays predictable
  task automatic wirq(input int n);
    g = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      if (timer_irq === 1'b1) g = 1'b1;
    end
  endtask

  task automatic cfg(input tcc_pkg::tcc_mode_t m, input logic pol, input logic [2:0] ex,
                     input logic [1:0] src, input logic oen, input logic [15:0] cnt,
                     input logic [15:0] rl);
    wr(`TCC_OFF_CTRL0, 32'h0);
    wr(`TCC_OFF_CTRL0, {24'h0, pol, ex, m[2:0], 1'b0});
    wr(`TCC_OFF_CTRL1, {27'h0, oen, 1'b0, src, m[3]});
    wr(`TCC_OFF_COUNT, {16'h0, cnt});
    wr(`TCC_OFF_RELOAD, {16'h0, rl});
    wr(`TCC_OFF_CAPTURE, 32'h0);
    wr(`TCC_OFF_CTRL0, {24'h0, pol, ex, m[2:0], 1'b1});
  endtask

  task automatic reset_values;
    rd(`TCC_OFF_CTRL0);
    `CHK("ctrl0", 32'h0, rdat)
    rd(`TCC_OFF_CTRL1);
    `CHK("ctrl1", 32'h0, rdat)
    rd(`TCC_OFF_COUNT);
    `CHK("count", 32'h1, rdat)
    rd(`TCC_OFF_RELOAD);
    `CHK("reload", 32'hffff, rdat)
    rd(`TCC_OFF_CAPTURE);
    `CHK("capture", 32'h0, rdat)
    rd(`TCC_OFF_STATUS);
    `CHK("status", 32'h0, rdat)
    rd(12'h018);
    `CHK("unmapped_err", 1'b1, serr)
    `CHK("unmapped_data", 32'h0, rdat)
  endtask

  task automatic compare_mode;
    cfg(tcc_pkg::TCC_MODE_COMPARE, 1'b0, 3'h0, 2'h0, 1'b1, 16'h000e, 16'h0010);
    wirq(40);
    `CHK("cmp_irq", 1'b1, g)
    `CHK("cmp_out", 1'b1, timer_out)
    `CHK("out_en", 1'b1, timer_out_en)
    wr(`TCC_OFF_CTRL0, 32'h4);
    rd(`TCC_OFF_COUNT);
    `CHK("cmp_keep", 1'b1, rdat[15:0] > 16'h0010)
    cfg(tcc_pkg::TCC_MODE_COMPARE, 1'b0, 3'h0, 2'h0, 1'b0, 16'hfffd, 16'h0005);
    wirq(30);
    `CHK("wrap_irq", 1'b1, g)
    // one tick every four cycles: eight ticks take 32 cycles
    // source code 3 must behave as both sources
    cfg(tcc_pkg::TCC_MODE_COMPARE, 1'b0, 3'h2, 2'h3, 1'b0, 16'h0001, 16'h0008);
    wirq(20);
    `CHK("pre_early", 1'b0, g)
    wirq(20);
    `CHK("pre_irq", 1'b1, g)
  endtask

  task automatic capture_restart;
    cfg(tcc_pkg::TCC_MODE_CAPRST, 1'b0, 3'h0, 2'h0, 1'b0, 16'h0001, 16'hffff);
    idle(30);
    lvl <= 1'b1;
    wirq(10);
    `CHK("cap_irq", 1'b1, g)
    wr(`TCC_OFF_CTRL0, 32'h0);
    rd(`TCC_OFF_CAPTURE);
    `CHK("cap_val", 1'b1, rdat[15:0] > 16'h001e && rdat[15:0] < 16'h0030)
    rd(`TCC_OFF_COUNT);
    `CHK("cap_restart", 1'b1, rdat[15:0] < 16'h0018)
    rd(`TCC_OFF_CTRL1);
    `CHK("cap_cause", 1'b1, rdat[3])
    lvl <= 1'b0;
    cfg(tcc_pkg::TCC_MODE_CAPRST, 1'b1, 3'h0, 2'h0, 1'b0, 16'h0001, 16'hffff);
    lvl <= 1'b1;
    wirq(10);
    `CHK("pol_rise", 1'b0, g)
    lvl <= 1'b0;
    wirq(10);
    `CHK("pol_fall", 1'b1, g)
    cfg(tcc_pkg::TCC_MODE_CAPRST, 1'b0, 3'h0, 2'h0, 1'b0, 16'h0001, 16'h0020);
    wirq(60);
    `CHK("rl_irq", 1'b1, g)
    rd(`TCC_OFF_CTRL1);
    `CHK("rl_cause", 1'b0, rdat[3])
    rd(`TCC_OFF_CAPTURE);
    `CHK("rl_capture", 32'h0, rdat)
    cfg(tcc_pkg::TCC_MODE_CAPRST, 1'b0, 3'h0, 2'h2, 1'b0, 16'h0001, 16'h0100);
    lvl <= 1'b1;
    wirq(10);
    `CHK("src_rl_cap", 1'b0, g)
    lvl <= 1'b0;
    cfg(tcc_pkg::TCC_MODE_CAPRST, 1'b0, 3'h0, 2'h1, 1'b0, 16'h0001, 16'h0020);
    wirq(60);
    `CHK("src_in_rl", 1'b0, g)
    lvl <= 1'b1;
    wirq(10);
    `CHK("src_in_cap", 1'b1, g)
  endtask

  task automatic gated_mode;
    lvl <= 1'b0;
    cfg(tcc_pkg::TCC_MODE_GATED, 1'b0, 3'h0, 2'h0, 1'b1, 16'h0030, 16'h0040);
    idle(10);
    rd(`TCC_OFF_COUNT);
    `CHK("gate_hold", 16'h0030, rdat[15:0])
    lvl <= 1'b1;
    wirq(40);
    `CHK("gate_rl", 1'b1, g)
    `CHK("gate_out", 1'b1, timer_out)
    // a second pass from 0030h would be past the reload by now
    wirq(25);
    `CHK("gate_pass", 1'b0, g)
    wirq(40);
    `CHK("gate_rl2", 1'b1, g)
    lvl <= 1'b0;
    wirq(10);
    `CHK("gate_off", 1'b1, g)
    cfg(tcc_pkg::TCC_MODE_GATED, 1'b0, 3'h0, 2'h2, 1'b0, 16'h0001, 16'h0040);
    lvl <= 1'b1;
    idle(5);
    lvl <= 1'b0;
    wirq(10);
    `CHK("gate_src", 1'b0, g)
    // input-only source: fast reloads stay quiet, the deassertion still interrupts
    cfg(tcc_pkg::TCC_MODE_GATED, 1'b0, 3'h0, 2'h1, 1'b0, 16'h0001, 16'h0004);
    lvl <= 1'b1;
    wirq(12);
    `CHK("gate_in_rl", 1'b0, g)
    lvl <= 1'b0;
    wirq(10);
    `CHK("gate_in_off", 1'b1, g)
  endtask

  task automatic capcmp_mode;
    lvl <= 1'b0;
    lag <= 4'h3;
    cfg(tcc_pkg::TCC_MODE_CAPCMP, 1'b0, 3'h0, 2'h0, 1'b0, 16'h0001, 16'h0040);
    idle(10);
    rd(`TCC_OFF_COUNT);
    `CHK("cc_wait", 16'h0001, rdat[15:0])
    lvl <= 1'b1;
    wirq(12);
    `CHK("cc_first", 1'b0, g)
    rd(`TCC_OFF_STATUS);
    `CHK("cc_armed", 1'b1, rdat[1])
    lvl <= 1'b0;
    idle(10);
    lvl <= 1'b1;
    wirq(12);
    `CHK("cc_cap", 1'b1, g)
    rd(`TCC_OFF_CTRL1);
    `CHK("cc_cause", 1'b1, rdat[3])
    rd(`TCC_OFF_CAPTURE);
    `CHK("cc_val", 1'b1, rdat[15:0] != 16'h0000)
    wirq(80);
    `CHK("cc_cmp", 1'b1, g)
    rd(`TCC_OFF_CTRL1);
    `CHK("cc_clear", 1'b0, rdat[3])
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    reset_values;
    compare_mode;
    capture_restart;
    gated_mode;
    capcmp_mode;
    stop_test;
  end
endmodule
